// ==== cc_advert_cfg.svh ====
// timing, current and encoding constants for the current advertisement link
`ifndef CC_ADVERT_CFG_SVH
`define CC_ADVERT_CFG_SVH
// ---------------------------------------------------------------
// clock and timing
// ---------------------------------------------------------------
`define CLK_KHZ 50000
`define BUS_ON_WIN_MS 200
`define VBUS_STABLE_MS 10
`define SINK_ADJ_MS 60
`define BMC_UI_CYC 8
`define BMC_HALF_CYC 4
`define BMC_BITS 8
// ---------------------------------------------------------------
// currents in mA and ratings in half watts
// ---------------------------------------------------------------
`define MA_UNCONF 13'h0064
`define MA_USB2 13'h01F4
`define MA_USB3_1L 13'h0384
`define MA_USB3_2L 13'h05DC
`define MA_1A5 13'h05DC
`define MA_3A0 13'h0BB8
`define MA_PER_CODE 13'h0032
`define HW_USB2 8'h05
`define HW_USB3_1L 8'h09
`define HW_1A5 8'h0F
`define HW_3A0 8'h1E
`define HW_THR_1A5 8'h0F
`define HW_THR_3A0 8'h1E
`endif

// ==== cc_advert_pkg.sv ====
// types shared by both ends of the current advertisement link
package cc_advert_pkg;
  // pull-up setting code seen on the configuration channel
  typedef enum logic [1:0] {
    ADV_DEFAULT = 2'h0,
    ADV_1A5 = 2'h1,
    ADV_3A0 = 2'h2,
    ADV_RSVD = 2'h3
  } advert_t;
  // source supply sequencing
  typedef enum logic [1:0] {
    SRC_IDLE = 2'h0,
    SRC_POWER_UP = 2'h1,
    SRC_READY = 2'h3,
    SRC_FAULT = 2'h2
  } src_state_t;
  // usb data rate class of the sink
  typedef enum logic [1:0] {
    RATE_USB2 = 2'h0,
    RATE_USB3_1L = 2'h1,
    RATE_USB3_2L = 2'h2
  } usb_rate_t;
endpackage

// ==== cc_link_if.sv ====
// configuration channel link between source and sink ends
`timescale 1ns/1ps
`default_nettype none
interface cc_link_if;
  import cc_advert_pkg::*;
  advert_t source_pullup_advert; // pull-up setting
  logic vbus_on; // bus power applied
  logic cc_bmc; // bi-phase mark line
  modport source (output source_pullup_advert, output vbus_on, output cc_bmc);
  modport sink (input source_pullup_advert, input vbus_on, input cc_bmc);
endinterface
`default_nettype wire

// ==== cc_source_end.sv ====
// source end: pull-up advertisement policy, bus power and overcurrent guard
`include "cc_advert_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RQ1 - advertise one of Default, 1.5 A, 3.0 A
// RQ2 - Default means usb configured high-power current
// RQ3 - power-only sink on Default draws 500 mA max
// RQ4 - contract limit supersedes pull-up advertisement at sink
// RQ5 - levels map to 2.5/4.5/7.5/7.5/15 W ratings
// RQ6 - sink tracks changes within sink adjust window
// RQ7 - sink ignores advertisement during a contract
// RQ8 - apply bus power within the power-on window
// RQ9 - source guards against draw above advertisement
// RQ10 - high-current sink keeps decoding the sensed voltage
// RQ11 - charging port able to 1.5 A advertises it
// RQ12 - charging sink without charger uses standard levels
// RQ13 - contract messages use bi-phase mark on channel
// RQ14 - no contract messaging before bus power stable
// RQ15 - outside contract, level follows power rating
// RQ16 - shared charger may start at 1.5 A, raise later
// RQ17 - suspend may drop advertisement to Default
// RQ18 - rev 2 contract: 1.5/3.0 after acknowledged ready
// RQ19 - rev 3 contract: follow collision avoidance setting
// RQ20 - contract over advertisement over charging over base
// RQ21 - leaving contract falls back down that order
// RQ22 - two-bit level code, Default after reset
module cc_source_end #(
  parameter int unsigned VBUS_STABLE_CYC = `VBUS_STABLE_MS * `CLK_KHZ,
  parameter int unsigned SINK_ADJ_CYC = `SINK_ADJ_MS * `CLK_KHZ
) (
  cc_link_if.source LINK,
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic CE,
  input wire logic SOURCE_ATTACHED_STATE,
  input wire logic [7:0] POWER_RATING_WATTS,
  input wire logic BC12_EN,
  input wire logic SUPPORT_3A0,
  input wire logic SHARED_CHARGER,
  input wire logic RAISE_OFFER,
  input wire logic USB_SUSPEND,
  input wire logic PD_EN,
  input wire logic PD_REV3,
  input wire logic CONTRACT_REQ,
  input wire logic [6:0] CONTRACT_CODE,
  input wire logic GOODCRC_PS_RDY,
  input wire logic CA_SINK_TX_OK,
  input wire logic [12:0] DRAW_MA,
  output cc_advert_pkg::advert_t ADVERT,
  output logic VBUS_EN,
  output logic OVERCURRENT,
  output logic CONTRACT_ACTIVE,
  output logic PD_READY
);
  import cc_advert_pkg::*;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  src_state_t state_reg;
  src_state_t state_next;
  advert_t advert_reg;
  advert_t advert_next;
  advert_t rating_level;
  logic [31:0] stable_cnt_reg;
  logic [31:0] adj_cnt_reg;
  logic contract_reg;
  logic ack_seen_reg;
  logic over_limit;
  logic [12:0] limit_ma;
  logic tx_pend_reg;
  logic tx_busy_reg;
  logic [7:0] tx_shift_reg;
  logic [2:0] tx_bit_reg;
  logic [2:0] tx_phase_reg;
  logic bmc_reg;

  // ---------------------------------------------------------------
  // supply sequencing
  // ---------------------------------------------------------------
  // RQ8 power on at attach
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SRC_IDLE: if (SOURCE_ATTACHED_STATE) state_next = SRC_POWER_UP;
      SRC_POWER_UP: if (stable_cnt_reg == VBUS_STABLE_CYC - 1) state_next = SRC_READY;
      SRC_READY: if (over_limit) state_next = SRC_FAULT;
      SRC_FAULT: state_next = SRC_FAULT;
    endcase
    if (!SOURCE_ATTACHED_STATE) begin
      state_next = SRC_IDLE;
    end
    // RQ9 overload trips supply
    if (state_reg == SRC_POWER_UP && over_limit) begin
      state_next = SRC_FAULT;
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      state_reg <= SRC_IDLE;
    end else if (CE) begin
      state_reg <= state_next;
    end
  end

  // counts settling time before the link counts as stable
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      stable_cnt_reg <= 32'h0000_0000;
    end else if (CE) begin
      if (state_reg != SRC_POWER_UP) begin
        stable_cnt_reg <= 32'h0000_0000;
      end else begin
        stable_cnt_reg <= stable_cnt_reg + 32'h0000_0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // contract tracking
  // ---------------------------------------------------------------
  // RQ14 contract only on stable power
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      contract_reg <= 1'b0;
    end else if (CE) begin
      contract_reg <= PD_EN && CONTRACT_REQ && state_reg == SRC_READY;
    end
  end

  // RQ18 wait for acknowledged ready
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      ack_seen_reg <= 1'b0;
    end else if (CE) begin
      if (contract_reg && GOODCRC_PS_RDY) begin
        ack_seen_reg <= 1'b1;
      end else if (!contract_reg) begin
        ack_seen_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // level selection
  // ---------------------------------------------------------------
  // RQ15 level from power rating
  always_comb begin
    if (POWER_RATING_WATTS >= `HW_THR_3A0 && (SUPPORT_3A0 || PD_EN)) begin
      rating_level = ADV_3A0;
    end else if (POWER_RATING_WATTS >= `HW_THR_1A5) begin
      rating_level = ADV_1A5;
    end else begin
      rating_level = ADV_DEFAULT;
    end
    // RQ16 shared charger starts lower
    if (rating_level == ADV_3A0 && SHARED_CHARGER && !RAISE_OFFER) begin
      rating_level = ADV_1A5;
    end
    // RQ11 charging port without pd
    if (!PD_EN && BC12_EN && rating_level == ADV_3A0 && !SUPPORT_3A0) begin
      rating_level = ADV_1A5;
    end
  end

  // RQ20 contract outranks other sources
  always_comb begin
    advert_next = rating_level;
    if (!SOURCE_ATTACHED_STATE || state_reg == SRC_FAULT) begin
      advert_next = ADV_DEFAULT;
    end else if (contract_reg) begin
      if (PD_REV3) begin
        // RQ19 collision avoidance setting
        advert_next = CA_SINK_TX_OK ? ADV_3A0 : ADV_1A5;
      end else if (ack_seen_reg) begin
        advert_next = (rating_level == ADV_3A0) ? ADV_3A0 : ADV_1A5;
      end else begin
        advert_next = advert_reg;
      end
    end else if (PD_EN && USB_SUSPEND) begin
      // RQ17 suspend drops to default
      advert_next = ADV_DEFAULT;
    end
  end

  // RQ22 default after reset
  // RQ1 one level driven at a time
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      advert_reg <= ADV_DEFAULT;
    end else if (CE) begin
      advert_reg <= advert_next;
    end
  end

  // ---------------------------------------------------------------
  // overcurrent guard
  // ---------------------------------------------------------------
  // RQ2 default is base usb current
  always_comb begin
    unique case (advert_reg)
      ADV_3A0: limit_ma = `MA_3A0;
      ADV_1A5: limit_ma = `MA_1A5;
      default: limit_ma = `MA_USB3_2L;
    endcase
    if (contract_reg) begin
      limit_ma = 13'(CONTRACT_CODE) * `MA_PER_CODE;
    end
  end

  // grace after any advertisement change so the sink can settle; a step down is not a fault
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      adj_cnt_reg <= 32'h0000_0000;
    end else if (CE) begin
      if (advert_next != advert_reg) begin
        adj_cnt_reg <= SINK_ADJ_CYC;
      end else if (adj_cnt_reg != 32'h0000_0000) begin
        adj_cnt_reg <= adj_cnt_reg - 32'h0000_0001;
      end
    end
  end

  // RQ9 compare draw with limit
  assign over_limit = DRAW_MA > limit_ma && adj_cnt_reg == 32'h0000_0000;

  // ---------------------------------------------------------------
  // bi-phase mark frame transmitter
  // ---------------------------------------------------------------
  // RQ13 frame on contract change
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      tx_pend_reg <= 1'b0;
    end else if (CE) begin
      if ((contract_reg != CONTRACT_ACTIVE) && state_reg == SRC_READY) begin
        tx_pend_reg <= 1'b1; // set wins over the clear below
      end else if (!tx_busy_reg) begin
        tx_pend_reg <= 1'b0;
      end
    end
  end

  // boundary toggle each bit, extra mid-bit toggle for a one
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      tx_busy_reg <= 1'b0;
      tx_shift_reg <= 8'h00;
      tx_bit_reg <= 3'h0;
      tx_phase_reg <= 3'h0;
      bmc_reg <= 1'b0;
    end else if (CE) begin
      if (!tx_busy_reg) begin
        if (tx_pend_reg) begin
          tx_busy_reg <= 1'b1;
          tx_shift_reg <= {contract_reg, CONTRACT_CODE};
          tx_bit_reg <= 3'h0;
          tx_phase_reg <= 3'h0;
        end
      end else begin
        if (tx_phase_reg == 3'h0) begin
          bmc_reg <= ~bmc_reg;
        end else if (tx_phase_reg == 3'(`BMC_HALF_CYC) && tx_shift_reg[7]) begin
          bmc_reg <= ~bmc_reg;
        end
        tx_phase_reg <= tx_phase_reg + 3'h1;
        if (tx_phase_reg == 3'(`BMC_UI_CYC - 1)) begin
          tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
          tx_bit_reg <= tx_bit_reg + 3'h1;
          if (tx_bit_reg == 3'(`BMC_BITS - 1)) begin
            tx_busy_reg <= 1'b0;
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  // RQ8 supply follows sequencing
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      VBUS_EN <= 1'b0;
      OVERCURRENT <= 1'b0;
      CONTRACT_ACTIVE <= 1'b0;
      PD_READY <= 1'b0;
    end else if (CE) begin
      VBUS_EN <= state_next == SRC_POWER_UP || state_next == SRC_READY;
      OVERCURRENT <= state_next == SRC_FAULT;
      CONTRACT_ACTIVE <= contract_reg;
      PD_READY <= state_reg == SRC_READY;
    end
  end

  assign ADVERT = advert_reg;
  assign LINK.source_pullup_advert = advert_reg;
  assign LINK.vbus_on = VBUS_EN;
  assign LINK.cc_bmc = bmc_reg;
endmodule
`default_nettype wire

// ==== cc_sink_end.sv ====
// sink end: decodes the advertisement and contract frames, sets its draw limit
`include "cc_advert_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module cc_sink_end #(
  parameter int unsigned VBUS_STABLE_CYC = `VBUS_STABLE_MS * `CLK_KHZ
) (
  cc_link_if.sink LINK,
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic CE,
  input wire logic WANT_HIGH,
  input wire logic POWER_ONLY_SINK_DEVICE,
  input wire logic BC12_FOUND,
  input wire logic USB_CONFIGURED,
  input wire cc_advert_pkg::usb_rate_t USB_RATE,
  output logic [12:0] LIMIT_MA,
  output logic [7:0] LIMIT_HALF_WATTS,
  output logic PD_CONTRACT,
  output cc_advert_pkg::advert_t ADVERT_SEEN
);
  import cc_advert_pkg::*;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [31:0] stable_cnt_reg;
  logic stable;
  logic bmc_q_reg;
  logic rx_busy_reg;
  logic [5:0] rx_cnt_reg;
  logic rx_start_reg;
  logic [7:0] rx_shift_reg;
  logic [12:0] limit_next;
  logic [7:0] hw_next;
  logic [12:0] base_ma;

  // RQ14 wait for stable power
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      stable_cnt_reg <= 32'h0000_0000;
    end else if (CE) begin
      if (!LINK.vbus_on) begin
        stable_cnt_reg <= 32'h0000_0000;
      end else if (!stable) begin
        stable_cnt_reg <= stable_cnt_reg + 32'h0000_0001;
      end
    end
  end
  assign stable = stable_cnt_reg >= VBUS_STABLE_CYC;

  // ---------------------------------------------------------------
  // bi-phase mark frame receiver
  // ---------------------------------------------------------------
  // RQ13 decode frame: bit is one when level moved by mid-bit
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      bmc_q_reg <= 1'b0;
      rx_busy_reg <= 1'b0;
      rx_cnt_reg <= 6'h00;
      rx_start_reg <= 1'b0;
      rx_shift_reg <= 8'h00;
      PD_CONTRACT <= 1'b0;
    end else if (CE) begin
      bmc_q_reg <= LINK.cc_bmc;
      if (!LINK.vbus_on) begin
        rx_busy_reg <= 1'b0;
        PD_CONTRACT <= 1'b0; // detach ends any contract
      end else if (!rx_busy_reg) begin
        if (stable && LINK.cc_bmc != bmc_q_reg) begin
          rx_busy_reg <= 1'b1;
          rx_cnt_reg <= 6'h01;
        end
      end else begin
        rx_cnt_reg <= rx_cnt_reg + 6'h01;
        if (rx_cnt_reg[2:0] == 3'h2) begin
          rx_start_reg <= LINK.cc_bmc;
        end
        if (rx_cnt_reg[2:0] == 3'h6) begin
          rx_shift_reg <= {rx_shift_reg[6:0], LINK.cc_bmc ^ rx_start_reg};
          if (rx_cnt_reg[5:3] == 3'(`BMC_BITS - 1)) begin
            rx_busy_reg <= 1'b0;
            PD_CONTRACT <= rx_shift_reg[6]; // first bit sent is contract flag
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // advertisement tracking
  // ---------------------------------------------------------------
  // RQ7 frozen during a contract
  // RQ10 high-current sink keeps decoding
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      ADVERT_SEEN <= ADV_DEFAULT;
    end else if (CE) begin
      if (!LINK.vbus_on || !WANT_HIGH) begin
        ADVERT_SEEN <= ADV_DEFAULT;
      end else if (!PD_CONTRACT) begin
        ADVERT_SEEN <= LINK.source_pullup_advert;
      end
    end
  end

  // RQ2 default by data rate
  // RQ12 standard levels without charger
  always_comb begin
    unique case (USB_RATE)
      RATE_USB3_1L: base_ma = `MA_USB3_1L;
      RATE_USB3_2L: base_ma = `MA_USB3_2L;
      default: base_ma = `MA_USB2;
    endcase
    if (!USB_CONFIGURED) begin
      base_ma = `MA_UNCONF;
    end
  end

  // RQ20 precedence of limits
  // RQ21 fallback when contract ends
  always_comb begin
    limit_next = base_ma;
    if (PD_CONTRACT) begin
      // RQ4 contract sets the limit
      limit_next = 13'(rx_shift_reg[6:0]) * `MA_PER_CODE;
    end else if (ADVERT_SEEN == ADV_3A0) begin
      limit_next = `MA_3A0;
    end else if (ADVERT_SEEN == ADV_1A5 || BC12_FOUND) begin
      limit_next = `MA_1A5;
    end else if (POWER_ONLY_SINK_DEVICE) begin
      // RQ3 power-only sink cap
      limit_next = `MA_USB2;
    end
    if (!LINK.vbus_on) begin
      limit_next = 13'h0000;
    end
  end

  // RQ5 equivalent rating per level
  always_comb begin
    if (limit_next >= `MA_3A0) begin
      hw_next = `HW_3A0;
    end else if (limit_next >= `MA_1A5) begin
      hw_next = `HW_1A5;
    end else if (limit_next >= `MA_USB3_1L) begin
      hw_next = `HW_USB3_1L;
    end else if (limit_next >= `MA_USB2) begin
      hw_next = `HW_USB2;
    end else begin
      hw_next = 8'h00;
    end
  end

  // RQ6 limit follows a rate, configured, charger or power-only input change one clock later, a link advertisement or WANT_HIGH change two clocks later
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      LIMIT_MA <= 13'h0000;
      LIMIT_HALF_WATTS <= 8'h00;
    end else if (CE) begin
      LIMIT_MA <= limit_next;
      LIMIT_HALF_WATTS <= hw_next;
    end
  end
endmodule
`default_nettype wire

// ==== cc_link_asserts.sv ====
// concurrent checks on the link between the two ends
`timescale 1ns/1ps
`default_nettype none
module cc_link_asserts #(
  parameter int unsigned VBUS_STABLE_CYC = 20
) (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire cc_advert_pkg::advert_t source_pullup_advert,
  input wire logic vbus_on,
  input wire logic cc_bmc
);
  import cc_advert_pkg::*;
  int unsigned on_cnt;

  // ---------------------------------------------------------------
  // helper logic
  // ---------------------------------------------------------------
  // powered cycles, saturating so it cannot wrap
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      on_cnt <= 0;
    end else if (!vbus_on) begin
      on_cnt <= 0;
    end else if (on_cnt < VBUS_STABLE_CYC) begin
      on_cnt <= on_cnt + 1;
    end
  end

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);

  // edges of the line stand at least four cycles apart
  sequence s_edge;
    $changed(cc_bmc);
  endsequence
  sequence s_hold;
    $stable(cc_bmc) [*3];
  endsequence
  sequence s_dark;
    !vbus_on [*2];
  endsequence

  property p_reset_default;
    $rose(NRST) |-> source_pullup_advert == ADV_DEFAULT && !vbus_on && !cc_bmc;
  endproperty
  property p_no_rsvd;
    source_pullup_advert != ADV_RSVD;
  endproperty
  property p_raise_powered;
    $changed(source_pullup_advert) && source_pullup_advert != ADV_DEFAULT |-> vbus_on;
  endproperty
  property p_power_from_default;
    $rose(vbus_on) |-> $past(source_pullup_advert) == ADV_DEFAULT;
  endproperty
  property p_fault_default;
    $fell(vbus_on) |=> source_pullup_advert == ADV_DEFAULT;
  endproperty
  property p_dark_default;
    s_dark |-> source_pullup_advert == ADV_DEFAULT;
  endproperty
  // no edge on the line until power has been on for the settling time
  property p_bmc_powered;
    s_edge |-> on_cnt == VBUS_STABLE_CYC;
  endproperty
  property p_bmc_spacing;
    s_edge |=> s_hold;
  endproperty

  a_reset_default: assert property (p_reset_default)
    else $error("link not idle after reset");
  a_no_rsvd: assert property (p_no_rsvd)
    else $error("reserved pull-up code");
  a_raise_powered: assert property (p_raise_powered)
    else $error("raise without bus power");
  a_power_from_default: assert property (p_power_from_default)
    else $error("power on while not Default");
  a_fault_default: assert property (p_fault_default)
    else $error("level kept after power off");
  a_dark_default: assert property (p_dark_default)
    else $error("level up while unpowered");
  a_bmc_powered: assert property (p_bmc_powered)
    else $error("frame before power stable");
  a_bmc_spacing: assert property (p_bmc_spacing)
    else $error("line edges too close");
endmodule
`default_nettype wire

// ==== testbench.sv ====
// bench joining source and sink ends over the link
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cc_advert_pkg::*;
  localparam int unsigned STABLE = 20;
  localparam int unsigned ADJ = 30;
  logic clk_sys = 1'h0, nrst = 1'h0, ce = 1'h1, attached = 1'h0;
  logic bc12_en = 1'h0, sup3a = 1'h0, shared = 1'h0, raise = 1'h0, susp = 1'h0;
  logic pd_en = 1'h1, pd_rev3 = 1'h0, c_req = 1'h0, goodcrc = 1'h0, ca_ok = 1'h0;
  logic want_high = 1'h1, pos = 1'h0, bc12_found = 1'h0, usb_cfg = 1'h1;
  logic [7:0] rating = 8'h00;
  logic [6:0] c_code = 7'h28;
  logic [12:0] draw = 13'h0000;
  usb_rate_t usb_rate = RATE_USB2;
  advert_t advert, advert_seen;
  logic vbus_en, oc, c_active, pd_ready, pd_contract;
  logic [12:0] limit_ma;
  logic [7:0] limit_hw;
  int n_errors = 0;
  int n_checks = 0;

  // ---------------------------------------------------------------
  // clock, ends and checker
  // ---------------------------------------------------------------
  always #10 clk_sys = ~clk_sys;
  cc_link_if link ();
  cc_source_end #(.VBUS_STABLE_CYC(STABLE), .SINK_ADJ_CYC(ADJ)) i_cc_source_end (
    .LINK(link), .CLK_SYS(clk_sys), .NRST(nrst), .CE(ce), .SOURCE_ATTACHED_STATE(attached),
    .POWER_RATING_WATTS(rating), .BC12_EN(bc12_en), .SUPPORT_3A0(sup3a),
    .SHARED_CHARGER(shared), .RAISE_OFFER(raise), .USB_SUSPEND(susp), .PD_EN(pd_en),
    .PD_REV3(pd_rev3), .CONTRACT_REQ(c_req), .CONTRACT_CODE(c_code), .GOODCRC_PS_RDY(goodcrc),
    .CA_SINK_TX_OK(ca_ok), .DRAW_MA(draw), .ADVERT(advert), .VBUS_EN(vbus_en),
    .OVERCURRENT(oc), .CONTRACT_ACTIVE(c_active), .PD_READY(pd_ready));
  cc_sink_end #(.VBUS_STABLE_CYC(STABLE)) i_cc_sink_end (
    .LINK(link), .CLK_SYS(clk_sys), .NRST(nrst), .CE(ce), .WANT_HIGH(want_high),
    .POWER_ONLY_SINK_DEVICE(pos), .BC12_FOUND(bc12_found), .USB_CONFIGURED(usb_cfg),
    .USB_RATE(usb_rate), .LIMIT_MA(limit_ma), .LIMIT_HALF_WATTS(limit_hw),
    .PD_CONTRACT(pd_contract), .ADVERT_SEEN(advert_seen));
  cc_link_asserts #(.VBUS_STABLE_CYC(STABLE)) i_cc_link_asserts (
    .CLK_SYS(clk_sys), .NRST(nrst), .source_pullup_advert(link.source_pullup_advert),
    .vbus_on(link.vbus_on), .cc_bmc(link.cc_bmc));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // outputs read at the falling edge, once settled
  task automatic step(input int n);
    repeat (n) tick();
    @(negedge clk_sys);
  endtask
  task automatic tick();
    @(posedge clk_sys);
  endtask
  // detach, clearing any fault, then attach with a rating
  task automatic plug(input logic [7:0] r);
    tick();
    attached <= 1'h0;
    rating <= r;
    step(2);
    tick();
    attached <= 1'h1;
    step(4);
  endtask
  // bounded wait: sel 1 power-ready, sel 0 contract flag
  task automatic wait_for(input logic sel, input logic v);
    for (int i = 0; i < 300 && (sel ? pd_ready : pd_contract) !== v; i++) tick();
    @(negedge clk_sys);
    check("wait", sel ? pd_ready : pd_contract, v);
  endtask
  task automatic test_done();
    if (n_errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  // rating thresholds, then default level per rate
  task automatic t_rating();
    logic [7:0] rat [4] = '{8'h0A, 8'h0F, 8'h1D, 8'h1E};
    advert_t adv [4] = '{ADV_DEFAULT, ADV_1A5, ADV_1A5, ADV_3A0};
    logic [12:0] lim [4] = '{13'h01F4, 13'h05DC, 13'h05DC, 13'h0BB8};
    logic [7:0] hw [4] = '{8'h05, 8'h0F, 8'h0F, 8'h1E};
    for (int i = 0; i < 4; i++) begin
      plug(rat[i]);
      check("vbus", vbus_en, 1'h1);
      check("advert", advert, adv[i]);
      check("seen", advert_seen, adv[i]);
      check("limit", limit_ma, lim[i]);
      check("watts", limit_hw, hw[i]);
    end
    plug(8'h0A);
    tick();
    usb_rate <= RATE_USB3_1L;
    step(3);
    check("limit", limit_ma, 13'h0384);
    check("watts", limit_hw, 8'h09);
    tick();
    usb_rate <= RATE_USB3_2L;
    step(3);
    check("limit", limit_ma, 13'h05DC);
    tick();
    pos <= 1'h1;
    step(3);
    check("limit", limit_ma, 13'h01F4);
    tick();
    pos <= 1'h0;
    usb_rate <= RATE_USB2;
  endtask
  // charging port without contracts
  task automatic t_bc12();
    tick();
    pd_en <= 1'h0;
    bc12_en <= 1'h1;
    plug(8'h1E);
    check("advert", advert, ADV_1A5);
    tick();
    sup3a <= 1'h1;
    step(3);
    check("advert", advert, ADV_3A0);
    plug(8'h0A);
    check("advert", advert, ADV_DEFAULT);
    check("limit", limit_ma, 13'h01F4);
    tick();
    bc12_found <= 1'h1;
    step(3);
    check("limit", limit_ma, 13'h05DC);
    tick();
    bc12_found <= 1'h0;
    sup3a <= 1'h0;
    bc12_en <= 1'h0;
    pd_en <= 1'h1;
  endtask
  // shared charger raises its offer later
  task automatic t_shared();
    tick();
    shared <= 1'h1;
    plug(8'h1E);
    check("advert", advert, ADV_1A5);
    tick();
    raise <= 1'h1;
    step(3);
    check("advert", advert, ADV_3A0);
    check("limit", limit_ma, 13'h0BB8);
    tick();
    shared <= 1'h0;
    raise <= 1'h0;
  endtask
  // suspend under frozen clock enable, then a draw fault
  task automatic t_suspend_fault();
    plug(8'h1E);
    tick();
    ce <= 1'h0;
    susp <= 1'h1;
    step(3);
    check("advert", advert, ADV_3A0);
    tick();
    ce <= 1'h1;
    step(3);
    check("advert", advert, ADV_DEFAULT);
    check("limit", limit_ma, 13'h01F4);
    tick();
    susp <= 1'h0;
    step(40);
    tick();
    draw <= 13'h0BB8;
    step(3);
    check("fault", oc, 1'h0);
    tick();
    draw <= 13'h0BB9;
    step(3);
    check("fault", oc, 1'h1);
    check("vbus", vbus_en, 1'h0);
    check("advert", advert, ADV_DEFAULT);
    tick();
    draw <= 13'h0000;
    attached <= 1'h0;
    step(3);
    check("fault", oc, 1'h0);
  endtask
  // rev 2 contract: level waits for acknowledged ready
  task automatic t_rev2();
    plug(8'h1E);
    check("ready", pd_ready, 1'h0);
    wait_for(1'h1, 1'h1);
    tick();
    susp <= 1'h1;
    c_req <= 1'h1;
    step(6);
    check("advert", advert, ADV_DEFAULT);
    wait_for(1'h0, 1'h1);
    check("limit", limit_ma, 13'h07D0);
    check("active", c_active, 1'h1);
    tick();
    goodcrc <= 1'h1;
    tick();
    goodcrc <= 1'h0;
    step(2);
    check("advert", advert, ADV_3A0);
    tick();
    rating <= 8'h0A;
    step(3);
    check("advert", advert, ADV_1A5);
    check("seen", advert_seen, ADV_DEFAULT);
    check("limit", limit_ma, 13'h07D0);
    tick();
    susp <= 1'h0;
    c_req <= 1'h0;
    wait_for(1'h0, 1'h0);
    step(3);
    check("advert", advert, ADV_DEFAULT);
    check("limit", limit_ma, 13'h01F4);
  endtask
  // rev 3 contract follows the avoidance input
  task automatic t_rev3();
    tick();
    pd_rev3 <= 1'h1;
    plug(8'h1E);
    wait_for(1'h1, 1'h1);
    tick();
    c_req <= 1'h1;
    step(3);
    check("advert", advert, ADV_1A5);
    tick();
    ca_ok <= 1'h1;
    step(3);
    check("advert", advert, ADV_3A0);
    wait_for(1'h0, 1'h1);
    tick();
    c_req <= 1'h0;
    ca_ok <= 1'h0;
    pd_rev3 <= 1'h0;
    wait_for(1'h0, 1'h0);
  endtask
  // mid-session reset drops power and advertisement
  task automatic t_reset();
    plug(8'h1E);
    tick();
    nrst <= 1'h0;
    step(3);
    check("advert", advert, ADV_DEFAULT);
    check("vbus", vbus_en, 1'h0);
    check("limit", limit_ma, 13'h0000);
    tick();
    nrst <= 1'h1;
    step(3);
  endtask

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (3) tick();
    nrst <= 1'h1;
    step(1);
    check("advert", advert, ADV_DEFAULT);
    t_rating();
    t_bc12();
    t_shared();
    t_suspend_fault();
    t_rev2();
    t_rev3();
    t_reset();
    test_done();
  end
  // under a thousand cycles expected; this is 25000 cycles, more than twenty-five times that
  initial begin
    #500_000;
    n_errors++;
    test_done();
  end
endmodule
`default_nettype wire
